// ### inc/nmf_pkg.sv
/*
  nmf_pkg: constants, register map and carrier types of the civil navigation
  message framer. Assumes a single 10 MHz system clock and an APB master.
*/
package nmf_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int NMF_CLK_PERIOD_NS = 100;
  localparam int NMF_SYM_PERIOD_NS = 10_000_000; // 100 symbols per second
  localparam int NMF_SYM_CYCLES = NMF_SYM_PERIOD_NS / NMF_CLK_PERIOD_NS;
  localparam int NMF_EPH_BCAST_S = 7200; // nominal broadcast of one data set
  localparam int NMF_MSG_S = 6;
  localparam logic [10:0] NMF_EPH_FRAMES = 11'(NMF_EPH_BCAST_S / NMF_MSG_S);
  // ---------------------------------------------------------------
  // message layout
  // ---------------------------------------------------------------
  localparam logic [8:0] NMF_MSG_BITS = 9'd300;
  localparam logic [8:0] NMF_BODY_BITS = 9'd276; // bits before parity
  localparam logic [8:0] NMF_LAST_BIT = 9'd299;
  localparam logic [7:0] NMF_SYNC = 8'h8B;
  localparam logic [23:0] NMF_CRC_POLY = 24'h864CFB;
  localparam logic [16:0] NMF_TOW_WRAP = 17'h189C0; // weeks of six-second steps
  localparam logic [237:0] NMF_FILLER = {119{2'h2}};
  localparam logic [6:0] NMF_G1 = 7'h79;
  localparam logic [6:0] NMF_G2 = 7'h5B;
  localparam logic [4:0] NMF_ACC_NONE = 5'h10; // -16: no prediction
  // ---------------------------------------------------------------
  // message types
  // ---------------------------------------------------------------
  localparam logic [5:0] NMF_T_DEFAULT = 6'h00;
  localparam logic [5:0] NMF_T_EPH1 = 6'h0A;
  localparam logic [5:0] NMF_T_EPH2 = 6'h0B;
  localparam logic [5:0] NMF_T_LO_A = 6'h0C; // 12..15 defined
  localparam logic [5:0] NMF_T_HI_A = 6'h0F;
  localparam logic [5:0] NMF_T_LO_B = 6'h1E; // 30..37 defined
  localparam logic [5:0] NMF_T_HI_B = 6'h25;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] NMF_A_CTRL = 12'h000;
  localparam logic [11:0] NMF_A_SLOT = 12'h004;
  localparam logic [11:0] NMF_A_WEEK = 12'h008;
  localparam logic [11:0] NMF_A_HEALTH = 12'h00C;
  localparam logic [11:0] NMF_A_EPOCH = 12'h010;
  localparam logic [11:0] NMF_A_ACC = 12'h014;
  localparam logic [11:0] NMF_A_TOW = 12'h018;
  localparam logic [11:0] NMF_A_EPHREF = 12'h01C;
  localparam logic [11:0] NMF_A_STATUS = 12'h020;
  localparam logic [11:0] NMF_A_BITIDX = 12'h024;
  localparam logic [11:0] NMF_A_PAY = 12'h040; // eight words up to 0x05C
  localparam logic [11:0] NMF_A_PAY_END = 12'h05C;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } nmf_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } nmf_apb_rsp_t;
  typedef struct packed {
    logic symbol;
    logic sym_strobe;
    logic data_bit;
    logic frame_start;
  } nmf_link_t;
endpackage

// ### core/nmf_framer.sv
/*
  nmf_framer: builds 300-bit navigation messages, appends parity, encodes them
  at rate one half and streams symbols. Registers are reached over APB.
  Assumes APB on CLK_SYS and a downstream modulator sampling on sym_strobe.
*/
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
module nmf_framer import nmf_pkg::*; #(
  parameter int SYM_CYCLES = NMF_SYM_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire nmf_apb_req_t APB_REQ,
  output nmf_apb_rsp_t APB_RSP,
  output nmf_link_t LINK
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic alert;
    logic gen_fail;
    logic [5:0] sat_identifier;
    logic [5:0] slot_type;
    logic slot_valid;
    logic [12:0] week;
    logic [2:0] health;
    logic [10:0] prediction_epoch;
    logic [4:0] range_accuracy_index;
    logic [16:0] week_time_count;
    logic [255:0] payload;
    logic [15:0] eph_ref;
    logic [10:0] eph_age;
    logic eph_live;
    logic rej_flag;
    logic rsv_flag;
    logic running;
    logic [19:0] tick;
    logic [19:0] sym_gap;
    logic half;
    logic [8:0] bit_idx;
    logic [275:0] shreg;
    logic [23:0] crc;
    logic [5:0] conv;
    logic [5:0] cur_type;
    logic [31:0] prdata;
    logic pslverr;
    nmf_link_t link;
  } nmf_state_t;

  nmf_state_t r;
  nmf_state_t next_r;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one serial step of the parity generator
  function automatic logic [23:0] crc_step(input logic [23:0] c, input logic b);
    logic fb;
    fb = b ^ c[23];
    return {c[22:0], 1'b0} ^ (fb ? NMF_CRC_POLY : 24'h000000);
  endfunction

  function automatic logic type_defined(input logic [5:0] t);
    return (t == NMF_T_DEFAULT) || (t == NMF_T_EPH1) || (t == NMF_T_EPH2) ||
      (t >= NMF_T_LO_A && t <= NMF_T_HI_A) || (t >= NMF_T_LO_B && t <= NMF_T_HI_B);
  endfunction

  // ---------------------------------------------------------------
  // message selection and assembly for the next slot
  // ---------------------------------------------------------------
  logic [5:0] sel_type;
  logic sel_reserved;
  logic [16:0] tow_next;
  logic [237:0] body;
  logic [275:0] frame;

  always_comb begin
    sel_reserved = r.slot_valid && !type_defined(r.slot_type);
    sel_type = r.slot_type;
    if (!r.slot_valid) begin
      sel_type = NMF_T_DEFAULT;
    end
    if (r.gen_fail || sel_reserved) begin
      sel_type = NMF_T_DEFAULT;
    end
    // an expired or missing data set counts as a failed ephemeris message
    if ((r.slot_type == NMF_T_EPH1 || r.slot_type == NMF_T_EPH2) && !r.eph_live) begin
      sel_type = NMF_T_DEFAULT;
    end
    // field carries time at start of the message after this one
    tow_next = (r.week_time_count == NMF_TOW_WRAP - 17'h00001) ? 17'h00000 :
      r.week_time_count + 17'h00001;
    if (sel_type == NMF_T_DEFAULT) begin
      body = NMF_FILLER;
    end else if (sel_type == NMF_T_EPH1) begin
      // week holds extension in its top three bits above the base count
      body = {r.week, r.health, r.prediction_epoch, r.range_accuracy_index,
        r.payload[205:0]};
    end else begin
      body = r.payload[237:0];
    end
    // msb lands on bit 1 of the message
    frame = {NMF_SYNC, r.sat_identifier, sel_type, tow_next, r.alert, body};
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup;
  logic wr_access;
  logic mapped;
  logic is_pay;
  logic [2:0] pay_word;
  logic [31:0] rd_mux;

  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign wr_access = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign is_pay = APB_REQ.paddr >= NMF_A_PAY && APB_REQ.paddr <= NMF_A_PAY_END &&
    APB_REQ.paddr[1:0] == 2'h0;
  assign pay_word = APB_REQ.paddr[4:2];

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (APB_REQ.paddr)
      NMF_A_CTRL: rd_mux = {18'h00000, r.sat_identifier, 5'h00, r.gen_fail, r.alert, r.enable};
      NMF_A_SLOT: rd_mux = {23'h000000, r.slot_valid, 2'h0, r.slot_type};
      NMF_A_WEEK: rd_mux = {19'h00000, r.week};
      NMF_A_HEALTH: rd_mux = {29'h00000000, r.health};
      NMF_A_EPOCH: rd_mux = {21'h000000, r.prediction_epoch};
      NMF_A_ACC: rd_mux = {27'h0000000, r.range_accuracy_index};
      NMF_A_TOW: rd_mux = {15'h0000, r.week_time_count};
      NMF_A_EPHREF: rd_mux = {16'h0000, r.eph_ref};
      NMF_A_STATUS: rd_mux = {18'h00000, r.cur_type, 4'h0, r.rsv_flag, r.rej_flag, r.eph_live, r.running};
      NMF_A_BITIDX: rd_mux = {23'h000000, r.bit_idx};
      default: begin
        if (is_pay) begin
          rd_mux = r.payload[pay_word * 32 +: 32];
        end else begin
          mapped = 1'b0; // unmapped: read zero, error
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic tick_done;
  logic data_bit;
  logic last_bit;

  assign tick_done = r.tick == 20'(SYM_CYCLES - 1);
  assign data_bit = (r.bit_idx < NMF_BODY_BITS) ? r.shreg[275] : r.crc[23];
  assign last_bit = r.bit_idx == NMF_LAST_BIT;

  always_comb begin
    next_r = r;
    next_r.link.sym_strobe = 1'b0;
    next_r.link.frame_start = 1'b0;
    // cycles since the last symbol strobe, only watched by the spacing check
    next_r.sym_gap = r.link.sym_strobe ? 20'h00001 : r.sym_gap + 20'h00001;
    // read data captured in setup so the access phase needs no wait
    if (setup) begin
      next_r.prdata = APB_REQ.pwrite ? 32'h00000000 : rd_mux;
      next_r.pslverr = !mapped;
    end
    if (wr_access && mapped) begin
      case (APB_REQ.paddr)
        NMF_A_CTRL: begin
          next_r.enable = APB_REQ.pwdata[0];
          next_r.alert = APB_REQ.pwdata[1];
          next_r.gen_fail = APB_REQ.pwdata[2];
          next_r.sat_identifier = APB_REQ.pwdata[13:8];
        end
        NMF_A_SLOT: begin
          next_r.slot_type = APB_REQ.pwdata[5:0];
          next_r.slot_valid = APB_REQ.pwdata[8];
        end
        NMF_A_WEEK: next_r.week = APB_REQ.pwdata[12:0];
        NMF_A_HEALTH: next_r.health = APB_REQ.pwdata[2:0];
        NMF_A_EPOCH: next_r.prediction_epoch = APB_REQ.pwdata[10:0];
        NMF_A_ACC: next_r.range_accuracy_index = APB_REQ.pwdata[4:0];
        NMF_A_TOW: next_r.week_time_count = APB_REQ.pwdata[16:0];
        NMF_A_EPHREF: begin
          // while a set is live, a new one with an unchanged reference time is refused
          if (r.eph_live && APB_REQ.pwdata[15:0] == r.eph_ref) begin
            next_r.rej_flag = 1'b1;
          end else begin
            next_r.eph_ref = APB_REQ.pwdata[15:0];
            next_r.eph_age = 11'h000;
            next_r.eph_live = 1'b1;
          end
        end
        NMF_A_STATUS: begin
          // write one to clear; a same-cycle event below still sets
          if (APB_REQ.pwdata[2]) next_r.rej_flag = 1'b0;
          if (APB_REQ.pwdata[3]) next_r.rsv_flag = 1'b0;
        end
        default: begin
          if (is_pay) begin
            next_r.payload[pay_word * 32 +: 32] = APB_REQ.pwdata;
          end
        end
      endcase
    end
    // symbol engine
    if (!r.running) begin
      next_r.tick = 20'h00000;
      next_r.half = 1'b0;
      if (r.enable) begin
        next_r.running = 1'b1;
        next_r.shreg = frame;
        next_r.crc = 24'h000000;
        next_r.bit_idx = 9'h000;
        next_r.conv = 6'h00;
        next_r.cur_type = frame[261:256];
        // the first message already stands for one six-second step
        next_r.week_time_count = tow_next;
        if (sel_reserved) next_r.rsv_flag = 1'b1;
      end
    end else if (tick_done) begin
      next_r.tick = 20'h00000;
      next_r.half = !r.half;
      next_r.link.sym_strobe = 1'b1;
      if (!r.half) begin
        // first symbol of a bit: new data enters the encoder
        next_r.link.data_bit = data_bit;
        next_r.link.symbol = ^(NMF_G1 & {data_bit, r.conv});
        next_r.link.frame_start = r.bit_idx == 9'h000;
        if (r.bit_idx < NMF_BODY_BITS) begin
          next_r.crc = crc_step(r.crc, data_bit);
          next_r.shreg = {r.shreg[274:0], 1'b0};
        end else begin
          next_r.crc = {r.crc[22:0], 1'b0};
        end
        next_r.bit_idx = r.bit_idx + 9'h001;
      end else begin
        next_r.link.symbol = ^(NMF_G2 & {r.link.data_bit, r.conv});
        next_r.conv = {r.link.data_bit, r.conv[5:1]};
        // next message follows with no gap; stopping only at a boundary
        if (r.bit_idx == NMF_MSG_BITS) begin
          next_r.bit_idx = 9'h000;
          next_r.shreg = frame;
          next_r.crc = 24'h000000;
          next_r.cur_type = frame[261:256];
          next_r.week_time_count = tow_next;
          if (r.eph_live) begin
            next_r.eph_age = r.eph_age + 11'h001;
            if (r.eph_age + 11'h001 == NMF_EPH_FRAMES) next_r.eph_live = 1'b0;
          end
          if (sel_reserved) next_r.rsv_flag = 1'b1;
          if (!r.enable) next_r.running = 1'b0;
        end
      end
    end else begin
      next_r.tick = r.tick + 20'h00001;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      r <= '0;
      r.range_accuracy_index <= NMF_ACC_NONE; // no prediction until loaded
    end else begin
      r <= next_r;
    end
  end

  assign APB_RSP.prdata = r.prdata;
  assign APB_RSP.pready = 1'b1;
  assign APB_RSP.pslverr = r.pslverr && APB_REQ.psel && APB_REQ.penable;
  assign LINK = r.link;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_sync_first: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (r.running && r.bit_idx == 9'h000) |-> r.shreg[275:268] == NMF_SYNC)
    else $error("message does not open with sync pattern");
  a_frame_len: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    r.bit_idx <= NMF_MSG_BITS)
    else $error("bit index beyond message length");
  a_crc_start: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (r.running && r.bit_idx == 9'h000 && r.half == 1'b0) |-> r.crc == 24'h000000)
    else $error("parity not cleared at message start");
  a_default_slot: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!r.slot_valid || r.gen_fail) |-> frame[261:256] == NMF_T_DEFAULT && body == NMF_FILLER)
    else $error("default message not chosen");
  a_no_reserved: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    type_defined(r.cur_type))
    else $error("reserved type in use");
  a_tow_step: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (r.running && tick_done && r.half && r.bit_idx == NMF_MSG_BITS && !(wr_access && APB_REQ.paddr == NMF_A_TOW))
    |=> r.week_time_count == $past(tow_next))
    else $error("time count did not advance per message");
  a_week_field: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (sel_type == NMF_T_EPH1) |-> frame[237:225] == r.week && frame[224:222] == r.health)
    else $error("type ten header misplaced");
  a_sym_pair: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (r.link.sym_strobe && !r.half) |-> r.sym_gap == 20'(SYM_CYCLES))
    else $error("symbol spacing wrong");

  // ---------------------------------------------------------------
  // stream checks
  // ---------------------------------------------------------------
  // a strobe lasts one cycle so the modulator never takes a symbol twice
  a_strobe_pulse: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    r.link.sym_strobe |=> !r.link.sym_strobe)
    else $error("symbol strobe longer than one cycle");
  // the message marker rides on the first symbol of bit one
  a_start_strobe: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    r.link.frame_start |-> r.link.sym_strobe && r.half)
    else $error("frame start away from first symbol");
  // bit one is the leading bit of the sync pattern
  a_sync_lead: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    r.link.frame_start |-> r.link.data_bit == NMF_SYNC[7])
    else $error("first bit is not the sync lead");
  // the data bit moves only with the first symbol of a bit
  a_data_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $changed(r.link.data_bit) |-> r.link.sym_strobe && r.half)
    else $error("data bit changed between symbols");
  // an idle framer sends no symbols
  a_idle_quiet: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !r.running |=> !r.link.sym_strobe)
    else $error("symbol sent while idle");
  // while enabled the next message follows the last bit directly
  a_no_gap: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (r.running && r.enable && tick_done && r.half && r.bit_idx == NMF_MSG_BITS) |=>
      r.running && r.bit_idx == 9'h000)
    else $error("gap between messages");
  // a data set is dropped once its two hours of broadcast are used up
  a_eph_expiry: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    r.eph_live |-> r.eph_age < NMF_EPH_FRAMES)
    else $error("ephemeris set sent past its broadcast window");
  // a reserved slot request is recorded when the default replaces it
  a_rsv_seen: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (r.running && tick_done && r.half && r.bit_idx == NMF_MSG_BITS && sel_reserved) |=>
      r.rsv_flag && r.cur_type == NMF_T_DEFAULT)
    else $error("reserved type not replaced and flagged");
  // type ten carries epoch and accuracy right after the health bits
  a_epoch_acc: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (sel_type == NMF_T_EPH1) |-> frame[221:211] == r.prediction_epoch &&
      frame[210:206] == r.range_accuracy_index)
    else $error("type ten epoch or accuracy misplaced");
  // the default body alternates, starting with a one
  a_filler_body: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (sel_type == NMF_T_DEFAULT) |-> frame[237] && frame[237:0] == NMF_FILLER)
    else $error("default body not alternating");
endmodule

// ### test/nmf_rx.sv
/*
  nmf_rx: receiver model that decodes the framer's symbol stream.
  Assumes LINK of nmf_framer and the same symbol period in clock cycles.
*/
`timescale 1ns/10ps
module nmf_rx import nmf_pkg::*; #(
  parameter int SYM = 4
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire nmf_link_t link,
  output logic [299:0] msg,
  output logic crc_ok,
  output int n_msg,
  output int err
);
  logic [299:0] sr;
  logic [5:0] hist;
  int sidx;
  int gap;
  // decoded flags a user would act on
  wire logic at_risk = msg[262];
  wire logic no_pred = (msg[234:230] == NMF_ACC_NONE);
  wire logic known = msg[285:280] inside {NMF_T_DEFAULT, NMF_T_EPH1, NMF_T_EPH2,
    [NMF_T_LO_A:NMF_T_HI_A], [NMF_T_LO_B:NMF_T_HI_B]};

  // residue over the whole message, zero when parity matches
  function automatic logic [23:0] residue(input logic [299:0] v);
    logic [23:0] c;
    c = '0;
    for (int i = 299; i >= 0; i--) begin
      c = {c[22:0], 1'b0} ^ ((v[i] ^ c[23]) ? NMF_CRC_POLY : 24'h000000);
    end
    return c;
  endfunction

  // ---------------------------------------------------------------
  // symbol capture
  // ---------------------------------------------------------------
  // errors are summed per cycle so that two faults are not folded into one
  always @(posedge CLK_SYS or negedge RSTN) begin : cap
    int s;
    int e;
    logic b;
    if (!RSTN) begin
      sidx <= 600;
      hist <= '0;
      gap <= 0;
      n_msg <= 0;
      err <= 0;
      sr <= '0;
      msg <= '0;
      crc_ok <= 1'b0;
    end else begin
      e = 0;
      s = link.frame_start ? 0 : sidx;
      b = link.data_bit;
      gap <= gap + 1;
      if (link.sym_strobe) begin
        gap <= 1;
        // spacing is only known once a message has begun
        if ((sidx < 600 || n_msg > 0) && gap != SYM) e++;
        if (link.frame_start && sidx < 600) e++;
        if (!link.frame_start && sidx == 600 && n_msg > 0) e++;
        if (s < 600) begin
          if (link.symbol !== ^({b, hist} & (s[0] ? NMF_G2 : NMF_G1))) e++;
          if (s[0])
            hist <= {b, hist[5:1]};
          else
            sr <= {sr[298:0], b};
          if (s == 599) begin
            msg <= sr;
            crc_ok <= (residue(sr) == 24'h000000);
            n_msg <= n_msg + 1;
          end
          sidx <= s + 1;
        end
      end
      err <= err + e;
    end
  end
endmodule

// ### test/nav_message_framer_tb_top.sv
/*
  nav_message_framer_tb_top: self-checking bench for nmf_framer.
  Assumes nmf_rx as the receiver and a shortened symbol period.
*/
`timescale 1ns/10ps
module nav_message_framer_tb_top import nmf_pkg::*; ;
  localparam int SYM = 4;
  typedef struct packed {
    logic [5:0] ty;
    logic vld;
    logic fail;
    logic alert;
    logic [5:0] ex;
  } nmf_row_t;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  nmf_apb_req_t req = '0;
  nmf_apb_rsp_t rsp;
  nmf_link_t link;
  logic [299:0] m;
  logic crc_ok;
  int n_msg;
  int rx_err;
  int n_fail = 0;
  int num_checks = 0;
  logic [255:0] pay;
  logic [31:0] rd;
  logic se;
  logic [16:0] t0;
  nmf_row_t rows [8];

  nmf_framer #(.SYM_CYCLES(SYM)) dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .APB_REQ(req), .APB_RSP(rsp),
    .LINK(link));
  nmf_rx #(.SYM(SYM)) rx (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .link(link), .msg(m), .crc_ok(crc_ok),
    .n_msg(n_msg), .err(rx_err));

  initial begin
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one transfer; an idle edge after it keeps drivers from meeting twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge CLK_SYS);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK_SYS);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      results();
    end
    rd = rsp.prdata;
    se = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge CLK_SYS);
  endtask

  task automatic wait_msg;
    int k;
    int n;
    n = n_msg;
    k = 0;
    while (n_msg == n && k < 3000) begin
      @(posedge CLK_SYS);
      k++;
    end
    if (k >= 3000) begin
      n_fail++;
      results();
    end
  endtask

  // the message in flight keeps old settings, so the second one is judged
  task automatic frame;
    wait_msg();
    t0 = m[279:263];
    wait_msg();
    chk(m[299:292], NMF_SYNC);
    chk(crc_ok, 1);
    chk(m[279:263], (t0 == NMF_TOW_WRAP - 1) ? 17'h00000 : t0 + 17'h00001);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rows = '{'{6'h0C, 1, 0, 0, 6'h0C}, '{6'h25, 1, 0, 1, 6'h25}, '{6'h1E, 1, 0, 0, 6'h1E},
      '{6'h05, 1, 0, 0, 6'h00}, '{6'h0C, 0, 0, 0, 6'h00}, '{6'h0F, 1, 1, 0, 6'h00},
      '{6'h0A, 1, 0, 0, 6'h00}, '{6'h10, 1, 0, 1, 6'h00}};
    repeat (6) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    @(posedge CLK_SYS);
    for (int i = 0; i < 8; i++) begin
      pay[32*i +: 32] = {8{i[3:0]}} ^ 32'h5A3C96E1;
      apb(1'b1, NMF_A_PAY + 12'(4 * i), pay[32*i +: 32]);
    end
    // start near the week wrap so the first row's message pair spans the rollover
    apb(1'b1, NMF_A_TOW, 32'(NMF_TOW_WRAP - 17'h00002));
    apb(1'b1, NMF_A_CTRL, 32'h00002A01);
    foreach (rows[i]) begin
      apb(1'b1, NMF_A_SLOT, {23'h000000, rows[i].vld, 2'h0, rows[i].ty});
      apb(1'b1, NMF_A_CTRL, {18'h00000, 6'h2A, 5'h00, rows[i].fail, rows[i].alert, 1'b1});
      frame();
      chk(m[291:286], 6'h2A);
      chk(m[285:280], rows[i].ex);
      chk(m[262], rows[i].alert);
      chk(m[261:24] === (rows[i].ex == NMF_T_DEFAULT ? NMF_FILLER : pay[237:0]), 1);
      $display("row %0d finished", i);
    end
    // ephemeris header with a negative accuracy index
    apb(1'b1, NMF_A_WEEK, 32'h000015A3);
    apb(1'b1, NMF_A_HEALTH, 32'h00000005);
    apb(1'b1, NMF_A_EPOCH, 32'h000006C1);
    apb(1'b1, NMF_A_ACC, 32'h0000001F);
    apb(1'b1, NMF_A_EPHREF, 32'h00001234);
    apb(1'b1, NMF_A_SLOT, 32'h0000010A);
    apb(1'b0, NMF_A_STATUS, 32'h00000000);
    chk(rd[1], 1);
    frame();
    chk(m[285:280], NMF_T_EPH1);
    chk(m[261:249], 13'h15A3);
    chk(m[248:246], 3'h5);
    chk(m[245:235], 11'h6C1);
    chk(m[234:230], 5'h1F);
    chk(m[229:24] === pay[205:0], 1);
    $display("ephemeris test finished");
    // a new set with an unchanged reference time is refused
    apb(1'b1, NMF_A_EPHREF, 32'h00001234);
    apb(1'b0, NMF_A_STATUS, 32'h00000000);
    chk(rd[2], 1);
    chk(rd[13:8], NMF_T_EPH1);
    apb(1'b1, NMF_A_STATUS, 32'h0000000C);
    apb(1'b0, NMF_A_STATUS, 32'h00000000);
    chk(rd[3:2], 0);
    apb(1'b0, 12'h030, 32'h00000000);
    chk(se, 1);
    chk(rd, 0);
    // disable lets the running message finish first
    apb(1'b1, NMF_A_CTRL, 32'h00000000);
    apb(1'b0, NMF_A_STATUS, 32'h00000000);
    chk(rd[0], 1);
    wait_msg();
    repeat (SYM + 2) @(posedge CLK_SYS);
    apb(1'b0, NMF_A_STATUS, 32'h00000000);
    chk(rd[0], 0);
    chk(rx_err, 0);
    $display("control test finished");
    // reset after the framer has stopped
    RSTN <= 1'b0;
    @(posedge CLK_SYS);
    chk(link, 0);
    chk(rsp.pready, 1);
    repeat (5) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    @(posedge CLK_SYS);
    apb(1'b0, NMF_A_ACC, 32'h00000000);
    chk(rd, {27'h0000000, NMF_ACC_NONE});
    apb(1'b0, NMF_A_CTRL, 32'h00000000);
    chk(rd, 0);
    $display("reset test finished");
    results();
  end
endmodule
